/* File: adc_readout_pkg.sv */
// constants and carrier types for the slave serial read-out port
package adc_readout_pkg;

	localparam int unsigned CHAN_BITS = 16;
	localparam int unsigned WORD_BITS = 32;
	localparam int unsigned CNT_BITS  = 6;
	localparam logic [5:0]  LAST_BIT  = 6'h1F;
	localparam logic [5:0]  WORD_DONE = 6'h20;
	localparam logic [5:0]  CNT_ONE   = 6'h01;
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;
	localparam logic [15:0] CHAN_RST  = 16'h0000;

	// host-side figures, kept for reference by benches and timing checks
	localparam int unsigned RDC_SCLK_MIN_IMPULSE_MHZ = 32;
	localparam int unsigned RDC_SCLK_MIN_NORMAL_MHZ  = 40;
	localparam int unsigned SPAN_SCLK_IMPULSE_MHZ    = 26;
	localparam int unsigned SPAN_SCLK_NORMAL_MHZ     = 30;
	localparam int unsigned HOST_SPI_MAX_MBPS        = 17;
	localparam int unsigned HOST_XFER_BITS           = 16;

	typedef struct packed {
		logic [CHAN_BITS-1:0] chanA;
		logic [CHAN_BITS-1:0] chanB;
	} result_pair_t;

	typedef struct packed {
		logic chipSelectN;
		logic readStrobeN;
		logic chainDataIn;
	} host_pins_t;

	typedef enum logic {
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} conv_state_t;

endpackage

/* File: bit_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
module bit_sync2 (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic din,
	output logic      dout
);

	logic stage1_reg;
	logic stage2_reg;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= din;
			stage2_reg <= stage1_reg;
		end
	end

	assign dout = stage2_reg;

endmodule

/* File: adc_slave_serial_readout.sv */
// slave serial read-out port: result word, shift logic, overrun detect
`timescale 1ns/1ns
module adc_slave_serial_readout
	import adc_readout_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	input  wire logic   convBusy,
	input  result_pair_t convResult,
	input  wire logic   chanOrderSel,
	input  wire logic   readDuringConv,
	input  wire logic   shiftClk,
	input  host_pins_t  hostPins,
	output logic        serialResultOut,
	output logic        serialResultOe,
	output logic        busyOut,
	output logic        readOverrunPulse
);

	////////////////////////////////////////////////////////////////////
	// synchronisers

	logic orderSync;
	logic rdcSync;
	logic csSync;
	logic rdSync;
	logic doneSync;
	logic cascadeLink;
	logic doneTog_reg;

	bit_sync2 uOrderSync (
		.clk  (sys_clk),
		.rstN (resetn),
		.din  (chanOrderSel),
		.dout (orderSync)
	);

	bit_sync2 uRdcSync (
		.clk  (sys_clk),
		.rstN (resetn),
		.din  (readDuringConv),
		.dout (rdcSync)
	);

	bit_sync2 uCsSync (
		.clk  (sys_clk),
		.rstN (resetn),
		.din  (~hostPins.chipSelectN),
		.dout (csSync)
	);

	bit_sync2 uRdSync (
		.clk  (sys_clk),
		.rstN (resetn),
		.din  (~hostPins.readStrobeN),
		.dout (rdSync)
	);

	bit_sync2 uDoneSync (
		.clk  (sys_clk),
		.rstN (resetn),
		.din  (doneTog_reg),
		.dout (doneSync)
	);

	// mode pin is static; link clock runs only in frames, two edges suffice
	bit_sync2 uCascadeSync (
		.clk  (shiftClk),
		.rstN (resetn),
		.din  (~readDuringConv),
		.dout (cascadeLink)
	);

	////////////////////////////////////////////////////////////////////
	// system side: result word, conversion tracking, overrun

	conv_state_t        state_reg;
	conv_state_t        state_next;
	logic [31:0]        word_reg;
	logic [31:0]        word_next;
	logic [31:0]        pend_reg;
	logic [31:0]        pend_next;
	logic               pendValid_reg;
	logic               pendValid_next;
	logic               started_reg;
	logic               started_next;
	logic               doneSeen_reg;
	logic               doneSeen_next;
	logic               overrun_reg;
	logic               overrun_next;
	logic               busyOut_reg;
	logic               busyOut_next;
	logic               frameSeen_reg;
	logic               frameSeen_next;
	logic               frameSys;
	logic               doneEv;
	logic [31:0]        resultWord;

	assign frameSys = csSync & rdSync;
	assign doneEv   = doneSync ^ doneSeen_reg;
	assign resultWord = orderSync ? {convResult.chanA, convResult.chanB}
	                              : {convResult.chanB, convResult.chanA};

	always_comb begin
		state_next     = state_reg;
		word_next      = word_reg;
		pend_next      = pend_reg;
		pendValid_next = pendValid_reg;
		started_next   = started_reg;
		doneSeen_next  = doneSync;
		frameSeen_next = frameSys;
		overrun_next   = 1'b0;
		busyOut_next   = convBusy;
		case (state_reg)
			CONV_IDLE: begin
				// held result goes live once the spanning read ends
				if (pendValid_reg && !frameSys) begin
					word_next      = pend_reg;
					pendValid_next = 1'b0;
				end
				if (convBusy) begin
					state_next   = CONV_RUN;
					started_next = frameSys;
				end
			end
			CONV_RUN: begin
				// only a new frame arms; the tail of a finished one must not
				if (frameSys && !frameSeen_reg)
					started_next = 1'b1;
				if (doneEv)
					started_next = 1'b0;
				if (!convBusy) begin
					state_next   = CONV_IDLE;
					started_next = 1'b0;
					// a finished read in this cycle wins over the overrun
					overrun_next = rdcSync && (started_reg || frameSys)
					               && !doneEv;
					// never swap the word under a read in progress
					if (frameSys) begin
						pend_next      = resultWord;
						pendValid_next = 1'b1;
					end else begin
						word_next = resultWord;
					end
				end
			end
			default: begin
				state_next = CONV_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= CONV_IDLE;
			word_reg      <= WORD_RST;
			pend_reg      <= WORD_RST;
			pendValid_reg <= 1'b0;
			started_reg   <= 1'b0;
			doneSeen_reg  <= 1'b0;
			overrun_reg   <= 1'b0;
			busyOut_reg   <= 1'b0;
			frameSeen_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			word_reg      <= word_next;
			pend_reg      <= pend_next;
			pendValid_reg <= pendValid_next;
			started_reg   <= started_next;
			doneSeen_reg  <= doneSeen_next;
			overrun_reg   <= overrun_next;
			busyOut_reg   <= busyOut_next;
			frameSeen_reg <= frameSeen_next;
		end
	end

	assign busyOut          = busyOut_reg;
	assign readOverrunPulse = overrun_reg;

	////////////////////////////////////////////////////////////////////
	// link side: shift register on the host's clock

	logic        linkRstN;
	logic [5:0]  bitCnt_reg;
	logic [5:0]  bitCnt_next;
	logic [31:0] shift_reg;
	logic [31:0] shift_next;
	logic        doneTog_next;
	logic        chainBit_reg;
	logic        chainBit_next;
	logic        shiftEn;
	logic        inBit;
	logic [31:0] shiftSrc;

	// chip select high holds the shifter in reset, so stray clocks do nothing
	assign linkRstN = resetn & ~hostPins.chipSelectN;
	assign inBit    = cascadeLink & chainBit_reg;
	assign shiftEn  = !hostPins.readStrobeN
	                  && (bitCnt_reg != WORD_DONE || cascadeLink);
	assign shiftSrc = (bitCnt_reg == 6'h00) ? word_reg : shift_reg;

	always_comb begin
		bitCnt_next  = bitCnt_reg;
		shift_next   = shift_reg;
		doneTog_next = doneTog_reg;
		if (shiftEn) begin
			if (bitCnt_reg != WORD_DONE)
				bitCnt_next = bitCnt_reg + CNT_ONE;
			// last plain bit is not shifted away, so the lsb stays out
			if (bitCnt_reg != LAST_BIT || cascadeLink)
				shift_next = {shiftSrc[30:0], inBit};
			else
				shift_next = shiftSrc;
			if (bitCnt_reg == LAST_BIT)
				doneTog_next = ~doneTog_reg;
		end
	end

	// data advances on the falling edge, stable through the rising one
	always_ff @(negedge shiftClk or negedge linkRstN) begin
		if (!linkRstN) begin
			bitCnt_reg <= 6'h00;
			shift_reg  <= WORD_RST;
		end else begin
			bitCnt_reg <= bitCnt_next;
			shift_reg  <= shift_next;
		end
	end

	always_ff @(negedge shiftClk or negedge resetn) begin
		if (!resetn)
			doneTog_reg <= 1'b0;
		else
			doneTog_reg <= doneTog_next;
	end

	assign chainBit_next = hostPins.chainDataIn;

	always_ff @(posedge shiftClk or negedge linkRstN) begin
		if (!linkRstN)
			chainBit_reg <= 1'b0;
		else
			chainBit_reg <= chainBit_next;
	end

	// before the first edge the msb comes straight from the result word
	assign serialResultOut = (bitCnt_reg == 6'h00) ? word_reg[WORD_BITS-1]
	                                               : shift_reg[WORD_BITS-1];
	assign serialResultOe  = !hostPins.chipSelectN
	                         && !hostPins.readStrobeN;

endmodule

/* File: adc_readout_properties.sv */
// concurrent checks on the pins of the slave serial read-out port
`timescale 1ns/1ns
module adc_readout_properties
	import adc_readout_pkg::*;
(
	input wire logic   sys_clk,
	input wire logic   resetn,
	input wire logic   convBusy,
	input result_pair_t convResult,
	input wire logic   chanOrderSel,
	input wire logic   readDuringConv,
	input wire logic   shiftClk,
	input host_pins_t  hostPins,
	input wire logic   serialResultOut,
	input wire logic   serialResultOe,
	input wire logic   busyOut,
	input wire logic   readOverrunPulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////
	// falling shift edges in the current frame, saturating
	logic [5:0] edgeCnt_reg;
	logic [5:0] edgeCnt_next;
	always_comb edgeCnt_next = &edgeCnt_reg ? edgeCnt_reg : edgeCnt_reg + CNT_ONE;
	always_ff @(negedge shiftClk or posedge hostPins.chipSelectN) begin
		if (hostPins.chipSelectN)
			edgeCnt_reg <= 6'h00;
		else
			edgeCnt_reg <= edgeCnt_next;
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_convEnd; $fell(busyOut); endsequence
	property p_oe; serialResultOe == (!hostPins.chipSelectN && !hostPins.readStrobeN); endproperty
	property p_bsyUp; $rose(convBusy) |=> busyOut; endproperty
	property p_bsyDn; $fell(convBusy) |=> !busyOut; endproperty
	property p_ovrWhen; readOverrunPulse |-> s_convEnd; endproperty
	property p_ovrOne; readOverrunPulse |=> !readOverrunPulse; endproperty
	property p_ovrMode; readOverrunPulse |-> readDuringConv; endproperty
	// a change seen with the shift clock high would break sampling on rise
	property p_bitHold; serialResultOe && $changed(serialResultOut) |-> !shiftClk; endproperty
	property p_lsbHold;
		serialResultOe && readDuringConv && edgeCnt_reg == WORD_DONE |-> $stable(serialResultOut);
	endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	a_bsyUp: assert property (p_bsyUp) else $error("busy late");
	a_bsyDn: assert property (p_bsyDn) else $error("ready late");
	a_ovrWhen: assert property (p_ovrWhen) else $error("stray overrun");
	a_ovrOne: assert property (p_ovrOne) else $error("overrun long");
	a_ovrMode: assert property (p_ovrMode) else $error("overrun mode");
	a_bitHold: assert property (p_bitHold) else $error("bit moved");
	a_lsbHold: assert property (p_lsbHold) else $error("lsb moved");
endmodule
bind adc_slave_serial_readout adc_readout_properties adc_readout_properties_inst (.*);

/* File: host_model.sv */
// host side: gated shift clock, select and read strobes, chain level
`timescale 1ns/1ns
module host_model
	import adc_readout_pkg::*;
(
	input wire logic  serialResultOut,
	input wire logic  chainLevel,
	output logic      shiftClk,
	output host_pins_t hostPins
);
	logic csN;
	logic rdN;
	// chain input held at a fixed level by the host
	assign hostPins = '{csN, rdN, chainLevel};
	initial begin
		shiftClk = 1'b0; // idle low, stands still between frames
		csN = 1'b1;
		rdN = 1'b1;
	end
	task automatic read(input int n, output logic [63:0] d);
		d = '0;
		#5 csN = 1'b0;
		rdN = 1'b0;
		#30;
		for (int i = 0; i < n; i++) begin
			if (i == 16)
				#40; // second 16-bit transfer, select kept low
			#24 shiftClk = 1'b1;
			d = {d[62:0], serialResultOut}; // sample on rise
			#24 shiftClk = 1'b0;
		end
		#24 csN = 1'b1;
		rdN = 1'b1;
	endtask
endmodule

/* File: tb.sv */
// self-checking bench for the slave serial read-out port
`timescale 1ns/1ns
module tb;
	import adc_readout_pkg::*;
	logic sys_clk, resetn, convBusy, chanOrderSel, readDuringConv, chainLevel;
	logic shiftClk, serialResultOut, serialResultOe, busyOut, readOverrunPulse;
	result_pair_t convResult, r1, r2;
	host_pins_t hostPins;
	int err_count, cmp_count, ovrCount, cycles;
	logic [63:0] got;
	adc_slave_serial_readout adc_slave_serial_readout_inst (.*);
	host_model host_model_inst (.*);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] word(result_pair_t p, logic ord);
		return ord ? {p.chanA, p.chanB} : {p.chanB, p.chanA};
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one conversion: result set and busy held high for n system clocks
	task automatic conv(input result_pair_t v, input int n);
		@(posedge sys_clk);
		convResult <= v;
		convBusy <= 1'b1;
		repeat (n) @(posedge sys_clk);
		convBusy <= 1'b0;
		@(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (readOverrunPulse === 1'b1)
			ovrCount++;
		if (cycles == 10000) begin
			err_count++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(81496));
		{resetn, convBusy, chanOrderSel, readDuringConv, chainLevel} = '0;
		convResult = '0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int k = 0; k < 4; k++) begin
			r1 = k == 0 ? result_pair_t'(32'h8000_0001) : result_pair_t'($urandom);
			chanOrderSel <= k[0];
			chainLevel <= k[1];
			conv(r1, 20);
			wait (busyOut === 1'b0);
			// bench link is faster than a slow master's ceiling
			host_model_inst.read(33, got);
			check(got, 64'({word(r1, k[0]), k[1]}));
			@(posedge sys_clk);
		end
		$display("read after conversion done");
		readDuringConv <= 1'b1;
		conv(r1, 20);
		for (int n = 32; n >= 16; n -= 16) begin
			r2 = result_pair_t'($urandom);
			ovrCount = 0;
			// bench link is slower than the fast clock asked for, so the
			// conversion is stretched and the read still ends early
			fork
				conv(r2, 260);
				host_model_inst.read(n, got);
			join
			repeat (3) @(posedge sys_clk);
			check(got, 64'(word(r1, 1'b1) >> (32 - n)));
			check(64'(ovrCount), 64'(n == 16));
			r1 = r2;
		end
		$display("read during conversion done");
		r2 = result_pair_t'($urandom);
		ovrCount = 0;
		fork
			begin
				// read starts first; next conversion starts mid-read
				repeat (40) @(posedge sys_clk);
				conv(r2, 300);
			end
			host_model_inst.read(32, got);
		join
		repeat (3) @(posedge sys_clk);
		check(got, 64'(word(r1, 1'b1)));
		check(64'(ovrCount), 64'h0);
		$display("read across conversion start done");
		end_sim();
	end
endmodule
